// ### nsp_page_access.sv
// Shared page access engine: RF page commands against tag, shared buffer, CPU
//
// Functional notes
// - 231 pages of four bytes each
// - Pages 0 to 3 ignore writes
// - Pages 4..131 shared with CPU unless bypass
// - Pages 135..225 reader only, never CPU; 132..134 are status, inbox, outbox
// - Pages 226..230 read-only to reader
// - Read returns four pages, zero padded
// - Range read limits 4 to 0xE6
// - Write updates exactly one page
// - Sixteen-byte write stores low four bytes
// - RF logic on recovered field clock
// - Inbox, outbox, status, buffer in page space
// - Access refused until password check passes
// - Segment zero fixed, segment boundary settable
// - Bypass bit gives reader whole tag memory
// - Shared buffer accesses pass an arbiter
module nsp_page_access #(
	parameter int ADDR_W = 8
) (
	// System clock domain
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CLK_EN,
	// Recovered RF field clock domain
	input wire logic RF_CLK,
	input wire logic RF_RSTN,
	// RF command request, RF clock domain
	input wire logic RF_REQ,
	input wire nsp_pkg::nsp_cmd_t RF_CMD,
	input wire logic [7:0] RF_START,
	input wire logic [7:0] RF_END,
	input wire logic [127:0] RF_WDATA,
	input wire logic RF_SELECTED,
	input wire logic RF_PASSWORD_OK,
	input wire logic RF_PROTECT_EN,
	output logic RF_BUSY,
	// RF answer byte stream, RF clock domain
	output logic RF_RVALID,
	output logic [7:0] RF_RDATA,
	output logic RF_RLAST,
	output logic RF_DONE,
	output logic RF_NAK,
	// Tag memory port, RF clock domain
	output logic TAG_WE,
	output logic [7:0] TAG_ADDR,
	output logic [31:0] TAG_WDATA,
	input wire logic [31:0] TAG_RDATA,
	// Processor side, system clock domain
	input wire logic CPU_BYPASS,
	input wire logic [7:0] CPU_SEG_BOUNDARY,
	input wire logic CPU_REQ,
	input wire logic CPU_WE,
	input wire logic [6:0] CPU_ADDR,
	input wire logic [31:0] CPU_WDATA,
	output logic CPU_ACK,
	output logic [31:0] CPU_RDATA,
	input wire logic [31:0] CPU_REPLY_OUTBOX,
	input wire logic [31:0] CPU_RF_STATUS_WORD,
	output logic [31:0] CPU_COMMAND_INBOX,
	output logic CPU_INBOX_EVENT
);
	import nsp_pkg::*;

	initial begin
		if (ADDR_W != 8) $error("nsp_page_access: ADDR_W must be 8");
	end

	// Shared buffer, 128 words, lives in the system domain
	logic [31:0] shared_mem [NSP_SHARED_WORDS];

	// Page is inside the shared window
	function automatic logic is_shared(input logic [7:0] p);
		return (p >= NSP_SHARED_FIRST) && (p <= NSP_SHARED_LAST);
	endfunction

	// Page may be written by the reader
	function automatic logic is_writable(input logic [7:0] p,
		input logic [7:0] bnd);
		return (p > NSP_RO_LO_LAST) && (p <= NSP_PRIV_LAST) && (p < bnd);
	endfunction

	// Synchronised bypass and boundary into the RF domain
	logic byp_s1_q, byp_s2_q;
	logic [7:0] bnd_s1_q, bnd_s2_q;
	// Two stages before any RF logic reads them
	always_ff @(posedge RF_CLK or negedge RF_RSTN) begin
		if (!RF_RSTN) begin
			byp_s1_q <= 1'b0;
			byp_s2_q <= 1'b0;
			bnd_s1_q <= NSP_RO_HI_FIRST;
			bnd_s2_q <= NSP_RO_HI_FIRST;
		end else begin
			byp_s1_q <= CPU_BYPASS;
			byp_s2_q <= byp_s1_q;
			bnd_s1_q <= CPU_SEG_BOUNDARY;
			bnd_s2_q <= bnd_s1_q;
		end
	end

	// Cross-domain request handshake, RF to system (toggle based)
	logic xreq_tgl_q;
	logic xack_tgl_q;
	logic xreq_we_q;
	logic [6:0] xreq_idx_q;
	logic [7:0] xreq_page_q;
	logic [31:0] xreq_wdata_q;
	logic [31:0] xrsp_data_q;
	logic ack_s1_q, ack_s2_q, ack_seen_q;

	// RF engine state
	nsp_rf_st_t st_q;
	nsp_cmd_t cmd_q;
	logic [7:0] page_q, end_q;
	logic [1:0] byte_q;
	logic [31:0] word_q;
	logic word_ok_q;
	logic pending_q;
	logic ack_edge;

	assign ack_edge = ack_s2_q ^ ack_seen_q;

	// Acknowledge toggle synchroniser into the RF domain
	always_ff @(posedge RF_CLK or negedge RF_RSTN) begin
		if (!RF_RSTN) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_seen_q <= 1'b0;
		end else begin
			ack_s1_q <= xack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_seen_q <= ack_s2_q;
		end
	end

	// Access is refused unless selected and, if protected, authenticated
	logic access_ok;
	assign access_ok = RF_SELECTED && (!RF_PROTECT_EN || RF_PASSWORD_OK);

	// Shared pages route to the arbiter unless bypass hands them to the tag
	logic route_shared;
	assign route_shared = !byp_s2_q && (is_shared(page_q) ||
		(page_q >= NSP_REG_STATUS && page_q <= NSP_REG_OUTBOX));

	// RF command engine on the recovered clock
	always_ff @(posedge RF_CLK or negedge RF_RSTN) begin
		if (!RF_RSTN) begin
			st_q <= NSP_RF_IDLE;
			cmd_q <= NSP_CMD_NONE;
			page_q <= 8'h00;
			end_q <= 8'h00;
			byte_q <= 2'h0;
			word_q <= 32'h0;
			word_ok_q <= 1'b0;
			pending_q <= 1'b0;
			xreq_tgl_q <= 1'b0;
			xreq_we_q <= 1'b0;
			xreq_idx_q <= 7'h0;
			xreq_page_q <= 8'h00;
			xreq_wdata_q <= 32'h0;
			RF_RVALID <= 1'b0;
			RF_RDATA <= 8'h00;
			RF_RLAST <= 1'b0;
			RF_DONE <= 1'b0;
			RF_NAK <= 1'b0;
			TAG_WE <= 1'b0;
			TAG_ADDR <= 8'h00;
			TAG_WDATA <= 32'h0;
		end else begin
			RF_RVALID <= 1'b0;
			RF_RLAST <= 1'b0;
			RF_DONE <= 1'b0;
			RF_NAK <= 1'b0;
			TAG_WE <= 1'b0;
			unique case (st_q)
				NSP_RF_IDLE: begin
					if (RF_REQ) begin
						cmd_q <= RF_CMD;
						page_q <= RF_START;
						byte_q <= 2'h0;
						word_ok_q <= 1'b0;
						if (!access_ok || RF_START > NSP_LAST_PAGE) begin
							RF_NAK <= 1'b1;
						end else if (RF_CMD == NSP_CMD_READ) begin
							end_q <= RF_START + 8'(NSP_READ_PAGES - 1);
							st_q <= NSP_RF_RD;
						end else if (RF_CMD == NSP_CMD_RANGE) begin
							if (RF_START < NSP_RANGE_MIN || RF_END > NSP_RANGE_MAX ||
								RF_END < RF_START) begin
								RF_NAK <= 1'b1;
							end else begin
								end_q <= RF_END;
								st_q <= NSP_RF_RD;
							end
						end else if (RF_CMD == NSP_CMD_WRITE ||
							RF_CMD == NSP_CMD_COMP) begin
							// Both write forms keep only the low word
							word_q <= RF_WDATA[31:0];
							st_q <= NSP_RF_COMP;
						end else begin
							RF_NAK <= 1'b1;
						end
					end
				end
				NSP_RF_COMP: begin
					// Read-only and out-of-segment pages ack but do not store
					if (!is_writable(page_q, bnd_s2_q)) begin
						RF_DONE <= 1'b1;
						st_q <= NSP_RF_IDLE;
					end else if (route_shared) begin
						xreq_we_q <= 1'b1;
						xreq_page_q <= page_q;
						xreq_idx_q <= 7'(page_q - NSP_SHARED_FIRST);
						xreq_wdata_q <= word_q;
						xreq_tgl_q <= ~xreq_tgl_q;
						pending_q <= 1'b1;
						st_q <= NSP_RF_WAIT;
					end else begin
						TAG_WE <= 1'b1;
						TAG_ADDR <= page_q;
						TAG_WDATA <= word_q;
						RF_DONE <= 1'b1;
						st_q <= NSP_RF_IDLE;
					end
				end
				NSP_RF_RD: begin
					if (!word_ok_q) begin
						if (page_q > NSP_LAST_PAGE) begin
							word_q <= {4{NSP_PAD_BYTE}};
							word_ok_q <= 1'b1;
						end else if (route_shared) begin
							xreq_we_q <= 1'b0;
							xreq_page_q <= page_q;
							xreq_idx_q <= 7'(page_q - NSP_SHARED_FIRST);
							xreq_tgl_q <= ~xreq_tgl_q;
							pending_q <= 1'b1;
							st_q <= NSP_RF_WAIT;
						end else begin
							TAG_ADDR <= page_q;
							st_q <= NSP_RF_DONE;
						end
					end else begin
						// Stream the word low byte first
						RF_RVALID <= 1'b1;
						RF_RDATA <= word_q[8*byte_q +: 8];
						byte_q <= byte_q + 2'h1;
						if (byte_q == 2'h3) begin
							word_ok_q <= 1'b0;
							page_q <= page_q + 8'h01;
							if (page_q == end_q) begin
								RF_RLAST <= 1'b1;
								RF_DONE <= 1'b1;
								st_q <= NSP_RF_IDLE;
							end
						end
					end
				end
				NSP_RF_DONE: begin
					// Tag word is valid while the address registered in NSP_RF_RD is held
					word_q <= TAG_RDATA;
					word_ok_q <= 1'b1;
					st_q <= NSP_RF_RD;
				end
				NSP_RF_WAIT: begin
					if (ack_edge && pending_q) begin
						pending_q <= 1'b0;
						if (xreq_we_q) begin
							RF_DONE <= 1'b1;
							st_q <= NSP_RF_IDLE;
						end else begin
							word_q <= xrsp_data_q;
							word_ok_q <= 1'b1;
							st_q <= NSP_RF_RD;
						end
					end
				end
				default: st_q <= NSP_RF_IDLE;
			endcase
		end
	end

	assign RF_BUSY = (st_q != NSP_RF_IDLE);

	// System side: request toggle synchroniser
	logic req_s1_q, req_s2_q, req_seen_q;
	logic [31:0] inbox_q, rsp_q;
	logic ack_q, inbox_evt_q;
	logic [31:0] cpu_rdata_q;
	logic rf_go;
	assign rf_go = req_s2_q ^ req_seen_q;

	// Request toggle stages; payload is stable while the toggle is pending
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else if (CLK_EN) begin
			req_s1_q <= xreq_tgl_q;
			req_s2_q <= req_s1_q;
		end
	end

	// Arbiter: RF request wins a cycle, CPU waits; never both at once
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			req_seen_q <= 1'b0;
			ack_q <= 1'b0;
			xack_tgl_q <= 1'b0;
			rsp_q <= 32'h0;
			inbox_q <= 32'h0;
			inbox_evt_q <= 1'b0;
			cpu_rdata_q <= 32'h0;
		end else if (CLK_EN) begin
			ack_q <= 1'b0;
			inbox_evt_q <= 1'b0;
			if (rf_go) begin
				req_seen_q <= req_s2_q;
				xack_tgl_q <= ~xack_tgl_q;
				if (xreq_page_q == NSP_REG_STATUS) begin
					rsp_q <= CPU_RF_STATUS_WORD;
				end else if (xreq_page_q == NSP_REG_INBOX) begin
					rsp_q <= inbox_q;
					if (xreq_we_q) begin
						inbox_q <= xreq_wdata_q;
						inbox_evt_q <= 1'b1;
					end
				end else if (xreq_page_q == NSP_REG_OUTBOX) begin
					rsp_q <= CPU_REPLY_OUTBOX;
				end else begin
					rsp_q <= shared_mem[xreq_idx_q];
				end
			end else if (CPU_REQ && !ack_q && !CPU_BYPASS) begin
				ack_q <= 1'b1;
				cpu_rdata_q <= shared_mem[CPU_ADDR];
			end
		end
	end

	// Shared buffer write port, one writer per cycle
	always_ff @(posedge MCLK) begin
		if (CLK_EN) begin
			if (rf_go && xreq_we_q && is_shared(xreq_page_q)) begin
				shared_mem[xreq_idx_q] <= xreq_wdata_q;
			end else if (!rf_go && CPU_REQ && !ack_q && !CPU_BYPASS &&
				CPU_WE) begin
				shared_mem[CPU_ADDR] <= CPU_WDATA;
			end
		end
	end

	assign xrsp_data_q = rsp_q;
	assign CPU_ACK = ack_q;
	assign CPU_RDATA = cpu_rdata_q;
	assign CPU_COMMAND_INBOX = inbox_q;
	assign CPU_INBOX_EVENT = inbox_evt_q;
endmodule

// ### nsp_pkg.sv
// Package for the shared page access block: page map and timing constants
package nsp_pkg;
	localparam int NSP_PAGES = 231;
	localparam int NSP_PAGE_BYTES = 4;
	localparam logic [7:0] NSP_RO_LO_LAST = 8'h03;
	localparam logic [7:0] NSP_SHARED_FIRST = 8'h04;
	localparam logic [7:0] NSP_SHARED_LAST = 8'h83;
	localparam logic [7:0] NSP_PRIV_LAST = 8'he1;
	localparam logic [7:0] NSP_RO_HI_FIRST = 8'he2;
	localparam logic [7:0] NSP_LAST_PAGE = 8'he6;
	localparam logic [7:0] NSP_RANGE_MIN = 8'h04;
	localparam logic [7:0] NSP_RANGE_MAX = 8'he6;
	localparam logic [7:0] NSP_PAD_BYTE = 8'h00;
	localparam int NSP_READ_PAGES = 4;
	localparam int NSP_COMP_BYTES = 16;
	localparam int NSP_SHARED_WORDS = 128;
	localparam logic [7:0] NSP_REG_STATUS = 8'h84;
	localparam logic [7:0] NSP_REG_INBOX = 8'h85;
	localparam logic [7:0] NSP_REG_OUTBOX = 8'h86;
	localparam real NSP_RF_CLK_MHZ = 6.78;
	localparam real NSP_SYS_CLK_MHZ = 25.0;
	// RF commands presented by the framing logic
	typedef enum logic [2:0] {
		NSP_CMD_READ = 3'b000,
		NSP_CMD_RANGE = 3'b001,
		NSP_CMD_WRITE = 3'b010,
		NSP_CMD_COMP = 3'b011,
		NSP_CMD_NONE = 3'b111
	} nsp_cmd_t;
	// RF side engine states
	typedef enum logic [2:0] {
		NSP_RF_IDLE = 3'b000,
		NSP_RF_RD = 3'b001,
		NSP_RF_WAIT = 3'b010,
		NSP_RF_COMP = 3'b011,
		NSP_RF_DONE = 3'b100
	} nsp_rf_st_t;
endpackage

// ### nsp_page_access_assertions.sv
// Concurrent checks on the ports of the shared page access engine
module nsp_page_access_assertions (
	// RF clock domain
	input wire logic RF_CLK,
	input wire logic RF_RSTN,
	input wire logic RF_REQ,
	input wire nsp_pkg::nsp_cmd_t RF_CMD,
	input wire logic [7:0] RF_START,
	input wire logic [7:0] RF_END,
	input wire logic RF_SELECTED,
	input wire logic RF_PASSWORD_OK,
	input wire logic RF_PROTECT_EN,
	input wire logic RF_BUSY,
	input wire logic RF_RVALID,
	input wire logic RF_RLAST,
	input wire logic RF_DONE,
	input wire logic RF_NAK,
	input wire logic TAG_WE,
	input wire logic [7:0] TAG_ADDR,
	// System clock domain
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CPU_REQ,
	input wire logic CPU_BYPASS,
	input wire logic CPU_ACK
);
	timeunit 1ns;
	timeprecision 1ps;
	import nsp_pkg::*;
	logic ok; // Reader selected and past the password check if needed
	assign ok = RF_SELECTED && (!RF_PROTECT_EN || RF_PASSWORD_OK);
	// Command taken at this edge
	sequence s_take;
		RF_REQ && !RF_BUSY;
	endsequence
	// Tag write strobe comes together with completion
	sequence s_wr_done;
		TAG_WE && RF_DONE;
	endsequence
	a_refuse_unauth: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) s_take ##0 !ok |=> RF_NAK)
		else $error("unauthorised command not refused");
	a_page_limit: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) s_take ##0 (ok && RF_START > NSP_LAST_PAGE)
		|=> RF_NAK) else $error("page past the end not refused");
	a_range_bounds: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) s_take ##0 (ok && RF_CMD == NSP_CMD_RANGE &&
		(RF_START < NSP_RANGE_MIN || RF_END > NSP_RANGE_MAX ||
		RF_END < RF_START)) |=> RF_NAK) else $error("bad range not refused");
	a_tag_write_time: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) s_take ##0 (ok && RF_CMD == NSP_CMD_WRITE &&
		RF_START inside {[8'h87:8'hbf]}) |-> ##2 s_wr_done)
		else $error("tag write not stored on time");
	a_low_read_only: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) TAG_WE |-> TAG_ADDR > NSP_RO_LO_LAST)
		else $error("store into low read-only page");
	a_high_read_only: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) TAG_WE |-> TAG_ADDR < NSP_RO_HI_FIRST)
		else $error("store into high read-only page");
	a_last_with_done: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) RF_RLAST |-> RF_DONE && RF_RVALID)
		else $error("last byte without completion");
	a_one_page_store: assert property (@(posedge RF_CLK)
		disable iff (!RF_RSTN) TAG_WE |=> !TAG_WE)
		else $error("more than one page stored");
	a_bypass_lockout: assert property (@(posedge MCLK)
		disable iff (!RSTN) CPU_BYPASS [*4] |-> !CPU_ACK)
		else $error("processor served during bypass");
	a_ack_has_cause: assert property (@(posedge MCLK)
		disable iff (!RSTN) CPU_ACK |-> $past(CPU_REQ))
		else $error("acknowledge without request");
endmodule

// ### nsp_tag_model.sv
// Tag memory model standing behind the page access engine
module nsp_tag_model (
	// RF clock
	input wire logic RF_CLK,
	// Memory port
	input wire logic TAG_WE,
	input wire logic [7:0] TAG_ADDR,
	input wire logic [31:0] TAG_WDATA,
	output logic [31:0] TAG_RDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:255]; // One word a page, 231 used
	// Seed each page with a pattern tied to its number
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {4{i[7:0]}} ^ 32'h33221100;
		end
	end
	// Combinational read: word follows the address in the same cycle
	assign TAG_RDATA = mem[TAG_ADDR];
	// One page per strobe, no read-modify of neighbours
	always @(posedge RF_CLK) begin
		if (TAG_WE) begin
			mem[TAG_ADDR] <= TAG_WDATA;
		end
	end
endmodule

// ### test_nsp_page_access.sv
// Self-checking bench for the shared page access engine
module test_nsp_page_access;
	timeunit 1ns;
	timeprecision 1ps;
	import nsp_pkg::*;
	logic MCLK = 1'b0, RF_CLK = 1'b0, RSTN = 1'b0, RF_RSTN = 1'b0;
	logic CLK_EN = 1'b1, RF_REQ = 1'b0, RF_SELECTED = 1'b0;
	logic RF_PASSWORD_OK = 1'b0, RF_PROTECT_EN = 1'b0;
	nsp_cmd_t RF_CMD = NSP_CMD_NONE;
	logic [7:0] RF_START = 8'h00, RF_END = 8'h00, CPU_SEG_BOUNDARY = 8'he2;
	logic [127:0] RF_WDATA = 128'h0;
	logic CPU_BYPASS = 1'b0, CPU_REQ = 1'b0, CPU_WE = 1'b0;
	logic [6:0] CPU_ADDR = 7'h00;
	logic [31:0] CPU_WDATA = 32'h0, CPU_REPLY_OUTBOX = 32'h0badcafe;
	logic [31:0] CPU_RF_STATUS_WORD = 32'h00000030;
	logic RF_BUSY, RF_RVALID, RF_RLAST, RF_DONE, RF_NAK, TAG_WE, CPU_ACK;
	logic CPU_INBOX_EVENT;
	logic [7:0] RF_RDATA, TAG_ADDR;
	logic [31:0] TAG_WDATA, TAG_RDATA, CPU_RDATA, CPU_COMMAND_INBOX;
	logic [127:0] rxd; // Read bytes, first byte lowest
	logic nak; // Last command was refused
	logic got_ack; // Last processor access was acknowledged
	int inbox_events = 0; // Inbox write pulses seen
	int bad_count = 0, checks = 0;
	nsp_page_access u_nsp_page_access (.*);
	nsp_tag_model u_nsp_tag_model (.*);
	// System clock 40 ns
	initial forever #20 MCLK = ~MCLK;
	// Field clock 48 ns, offset so the edges drift apart
	initial begin
		#7;
		forever #24 RF_CLK = ~RF_CLK;
	end
	// Expected tag word; pages past the end read as padding
	function automatic logic [31:0] tw(input logic [7:0] p);
		return (p > NSP_LAST_PAGE) ? 32'h0 : {4{p}} ^ 32'h33221100;
	endfunction
	// Count inbox pulses away from the edge that launches them
	always @(negedge MCLK) begin
		if (CPU_INBOX_EVENT === 1'b1) inbox_events++;
	end
	// Compare and count
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One reader command, gathering answer bytes until done or refused
	task automatic rf(input nsp_cmd_t c, input logic [7:0] s,
		input logic [7:0] e, input logic [127:0] w);
		int n;
		bit fin;
		n = 0;
		fin = 1'b0;
		nak = 1'b0;
		rxd = 128'h0;
		@(negedge RF_CLK);
		while (RF_BUSY) @(negedge RF_CLK);
		RF_CMD = c;
		RF_START = s;
		RF_END = e;
		RF_WDATA = w;
		RF_REQ = 1'b1;
		@(negedge RF_CLK);
		RF_REQ = 1'b0;
		// Look first, then wait: a refusal stands only the cycle after take
		for (int i = 0; i < 400 && !fin; i++) begin
			if (RF_RVALID === 1'b1 && n < 16) begin
				rxd[8*n +: 8] = RF_RDATA;
				n++;
			end
			fin = (RF_DONE === 1'b1) || (RF_NAK === 1'b1);
			nak = (RF_NAK === 1'b1);
			if (!fin) @(negedge RF_CLK);
		end
		if (!fin) bad_count++;
	endtask
	// One processor word access, request held until acknowledged or 100 cycles pass
	task automatic cpu(input logic we, input logic [6:0] a,
		input logic [31:0] d);
		@(negedge MCLK);
		CPU_WE = we;
		CPU_ADDR = a;
		CPU_WDATA = d;
		CPU_REQ = 1'b1;
		for (int i = 0; i < 100 && CPU_ACK !== 1'b1; i++) @(negedge MCLK);
		got_ack = (CPU_ACK === 1'b1);
		// Hold through the edge at which the acknowledge is sampled
		@(negedge MCLK);
		CPU_REQ = 1'b0;
	endtask
	// Read across the end of the page space
	task automatic t_read_end;
		rf(NSP_CMD_READ, 8'he4, 8'he4, 128'h0);
		for (int k = 0; k < 4; k++) begin
			check(rxd[32*k +: 32], tw(8'he4 + 8'(k)));
		end
		$display("test read_end done");
	endtask
	// Refused commands, last one without the password
	task automatic t_refuse;
		logic [7:0] st [5] = '{8'h03, 8'h0a, 8'h04, 8'he7, 8'h10};
		logic [7:0] en [5] = '{8'h08, 8'h09, 8'he7, 8'he7, 8'h10};
		RF_PROTECT_EN = 1'b1;
		for (int i = 0; i < 5; i++) begin
			RF_PASSWORD_OK = (i != 4);
			rf((i > 2) ? NSP_CMD_READ : NSP_CMD_RANGE, st[i], en[i], 128'h0);
			check({31'h0, nak}, 32'h1);
		end
		RF_PASSWORD_OK = 1'b1;
		rf(NSP_CMD_RANGE, 8'he5, 8'he6, 128'h0);
		check(rxd[63:0], {tw(8'he6), tw(8'he5)});
		$display("test refuse done");
	endtask
	// Stores to read-only and ordinary pages, then read back
	task automatic t_writes;
		rf(NSP_CMD_WRITE, 8'h02, 8'h02, 128'hffffffff);
		rf(NSP_CMD_WRITE, 8'he3, 8'he3, 128'hffffffff);
		rf(NSP_CMD_WRITE, 8'h90, 8'h90, 128'h5555_deadbeef);
		rf(NSP_CMD_COMP, 8'h91, 8'h91, {96'h0123_4567_89ab, 32'h1234abcd});
		rf(NSP_CMD_READ, 8'h00, 8'h00, 128'h0);
		check(rxd[95:64], tw(8'h02));
		rf(NSP_CMD_READ, 8'he2, 8'he2, 128'h0);
		check(rxd[63:32], tw(8'he3));
		rf(NSP_CMD_READ, 8'h90, 8'h90, 128'h0);
		check(rxd[31:0], 32'hdeadbeef);
		check(rxd[63:32], 32'h1234abcd);
		check(rxd[95:64], tw(8'h92));
		$display("test writes done");
	endtask
	// Movable segment boundary stops stores at and above it
	task automatic t_boundary;
		@(negedge MCLK);
		CPU_SEG_BOUNDARY = 8'hc0;
		repeat (8) @(negedge MCLK);
		rf(NSP_CMD_WRITE, 8'hc8, 8'hc8, 128'h7e57c0de);
		rf(NSP_CMD_READ, 8'hc8, 8'hc8, 128'h0);
		check(rxd[31:0], tw(8'hc8));
		@(negedge MCLK);
		CPU_SEG_BOUNDARY = 8'he2;
		repeat (8) @(negedge MCLK);
		rf(NSP_CMD_WRITE, 8'hc8, 8'hc8, 128'h7e57c0de);
		rf(NSP_CMD_READ, 8'hc8, 8'hc8, 128'h0);
		check(rxd[31:0], 32'h7e57c0de);
		$display("test boundary done");
	endtask
	// Shared buffer, page 131 and the command words
	task automatic t_shared;
		cpu(1'b1, 7'h05, 32'h12345678);
		rf(NSP_CMD_READ, 8'h09, 8'h09, 128'h0);
		check(rxd[31:0], 32'h12345678);
		rf(NSP_CMD_WRITE, 8'h83, 8'h83, 128'ha5a55a5a);
		cpu(1'b0, 7'h7f, 32'h0);
		check(CPU_RDATA, 32'ha5a55a5a);
		rf(NSP_CMD_WRITE, 8'h85, 8'h85, 128'hc0de0001);
		repeat (6) @(negedge MCLK);
		check(CPU_COMMAND_INBOX, 32'hc0de0001);
		check(32'(inbox_events), 32'h1);
		rf(NSP_CMD_READ, 8'h84, 8'h84, 128'h0);
		check(rxd[31:0], 32'h00000030);
		check(rxd[63:32], 32'hc0de0001);
		check(rxd[95:64], 32'h0badcafe);
		check(rxd[127:96], tw(8'h87));
		$display("test shared done");
	endtask
	// Bypass hands the whole window to tag memory
	task automatic t_bypass;
		@(negedge MCLK);
		CPU_BYPASS = 1'b1;
		repeat (8) @(negedge MCLK);
		// Processor must be locked out while the reader owns the window
		cpu(1'b1, 7'h0c, 32'hbad0bad0);
		check({31'h0, got_ack}, 32'h0);
		rf(NSP_CMD_WRITE, 8'h10, 8'h10, 128'h600dd00d);
		// Store lands one edge after the completion pulse
		@(negedge RF_CLK);
		check(u_nsp_tag_model.mem[16], 32'h600dd00d);
		rf(NSP_CMD_READ, 8'h84, 8'h84, 128'h0);
		check(rxd[31:0], tw(8'h84));
		$display("test bypass done");
	endtask
	// Counts, verdict, end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge MCLK);
		RSTN = 1'b1;
		@(negedge RF_CLK);
		RF_RSTN = 1'b1;
		RF_SELECTED = 1'b1;
		t_read_end;
		t_refuse;
		t_writes;
		t_boundary;
		t_shared;
		t_bypass;
		close_out;
	end
	// Watchdog well beyond the expected run
	initial begin
		#500000;
		bad_count++;
		close_out;
	end
endmodule
bind nsp_page_access nsp_page_access_assertions u_chk (.*);
